// File: rtl/pxa_expander.sv
/*
 * Two-wire target of a 16-port expander: an open-drain group with transition detection
 * and a push-pull group, each at its own strapped address.
 * Assumes the bus controller drives the serial clock well below a quarter of ref_clk.
 */
// Functional notes
// - START, address with direction, data, STOP.
// - Idle lines high; detect START and STOP.
// - Data stays stable while clock is high.
// - Ninth clock carries the receiver's acknowledge.
// - Device acks writes; controller acks reads.
// - Two addresses: open-drain group, push-pull group.
// - Eighth bit low writes, high reads.
// - Prefixes 110 for ports, 101 outputs.
// - Two four-level straps give low bits.
// - Strap codes map onto address bits.
// - Snapshot differs from inputs: assert alert.
// - Address ack clears flags and alert.
// - Second byte gives flags before clearing.
// - Longer reads alternate resampled data, flags.
// - Input sampled at the preceding acknowledge.
// - Sent data becomes snapshot; alert held off.
// - Changes during read alert only at STOP.
// - Push-pull reads resample pins each acknowledge.
// - Readback shows true pin level.
// - Write ack samples; alert cleared for ports.
// - Each written byte sets whole group.
// - Alert is open-drain, released when inactive.
`timescale 1ns/1ps
`default_nettype none

module pxa_expander (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_strap_high,
    input wire logic [1:0] addr_strap_low,
    input wire logic [pxa_pkg::BYTE_W-1:0] open_drain_io_ports_in,
    output logic [pxa_pkg::BYTE_W-1:0] open_drain_io_ports_out,
    output logic [pxa_pkg::BYTE_W-1:0] open_drain_io_ports_oe,
    input wire logic [pxa_pkg::BYTE_W-1:0] push_pull_outputs_in,
    output logic [pxa_pkg::BYTE_W-1:0] push_pull_outputs,
    output logic change_alert_n_out,
    output logic change_alert_oe
);
    import pxa_pkg::*;

    // Reset release flip-flops; the rest of the design uses the second.
    logic rst_meta_reg;
    logic rst_sync_n;
    // Synchronised pin levels.
    logic [21:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [1:0] strap_high_s;
    logic [1:0] strap_low_s;
    logic [7:0] io_s;
    logic [7:0] pp_s;
    // Previous serial levels for edge finding.
    logic scl_prev_reg;
    logic sda_prev_reg;
    // Strap capture.
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic [ADDR_W-1:0] io_addr_reg;
    logic [ADDR_W-1:0] pp_addr_reg;
    // Protocol engine.
    pxa_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic is_read_reg;
    logic is_pp_reg;
    logic odd_reg;
    logic sda_oe_reg;
    // Transition detection.
    logic [7:0] snapshot_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] saved_flags_reg;
    logic hold_reg;
    logic hold_next;
    logic alert_oe_reg;
    // Port drivers.
    logic [7:0] io_oe_reg;
    logic [7:0] pp_out_reg;
    // Bus events, each one cycle long.
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic ack_sample;
    logic snap_io;
    logic wr_apply;

    // Reset is asserted at once and released after two clean edges.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // Every pin input passes two flip-flops before any logic reads it.
    pxa_bit_sync #(
        .WIDTH(22),
        .RESET_VALUE(SYNC_RESET)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .din({scl_in, sda_in, addr_strap_high, addr_strap_low, open_drain_io_ports_in, push_pull_outputs_in}),
        .dout(pins_s)
    );

    // Unpack the synchronised bundle.
    assign {scl_s, sda_s, strap_high_s, strap_low_s, io_s, pp_s} = pins_s;

    // Keep the last serial levels so that edges can be found.
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    // Clock edges, and data edges under a high clock as START and STOP.
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // Acknowledge clock high edge where ports are sampled.
    assign ack_sample = scl_rise && ((state_reg == ST_ADDR_ACK) || ((state_reg == ST_RD_ACK) && !sda_s));
    // Open-drain sampling happens before every port-data byte and at a write's address.
    assign snap_io = ack_sample && !is_pp_reg && !odd_reg;
    // A received data byte is applied as its acknowledge begins.
    assign wr_apply = scl_fall && (state_reg == ST_WR_DATA) && (bit_cnt_reg == BIT_LAST);

    // The straps are caught once, after they have settled through the synchroniser.
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            io_addr_reg <= '0;
            pp_addr_reg <= '0;
        end
        else if (!strap_done_reg)
        begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == STRAP_SETTLE)
            begin
                // Both addresses share the four strapped low bits.
                strap_done_reg <= 1'b1;
                io_addr_reg <= {IO_PREFIX, strap_high_bits(strap_high_s), strap_low_bits(strap_low_s)};
                pp_addr_reg <= {PP_PREFIX, strap_high_bits(strap_high_s), strap_low_bits(strap_low_s)};
            end
        end
    end

    // Serial engine: address decode, acknowledges, byte shifting in both directions.
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            is_read_reg <= 1'b0;
            is_pp_reg <= 1'b0;
            odd_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (start_det)
        begin
            // A START, repeated or not, always opens a new address phase.
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            odd_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            // STOP frees the bus whatever state the transfer was in.
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_ADDR, ST_WR_DATA:
                begin
                    // Bits are taken on the clock's rising edge, when data is stable.
                    if (scl_rise && (bit_cnt_reg != BIT_LAST))
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && (bit_cnt_reg == BIT_LAST))
                    begin
                        if (state_reg == ST_WR_DATA)
                        begin
                            // Written bytes are always acknowledged.
                            sda_oe_reg <= 1'b1;
                            state_reg <= ST_WR_ACK;
                        end
                        else if (strap_done_reg && ((shift_reg[7:1] == io_addr_reg) || (shift_reg[7:1] == pp_addr_reg)))
                        begin
                            // Matching address: pull data low through the ninth clock.
                            sda_oe_reg <= 1'b1;
                            is_read_reg <= shift_reg[0];
                            is_pp_reg <= (shift_reg[7:1] == pp_addr_reg);
                            state_reg <= ST_ADDR_ACK;
                        end
                        else
                        begin
                            // Foreign address: stay silent until the next START or STOP.
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK:
                begin
                    if (ack_sample && is_read_reg)
                    begin
                        // Load the next byte: ports sampled during this acknowledge, or the saved flags.
                        if (is_pp_reg)
                        begin
                            tx_reg <= pp_s;
                        end
                        else if (odd_reg)
                        begin
                            tx_reg <= saved_flags_reg;
                        end
                        else
                        begin
                            tx_reg <= io_s;
                        end
                        odd_reg <= !is_pp_reg && !odd_reg;
                    end
                    else if (scl_rise && (state_reg == ST_RD_ACK))
                    begin
                        // No acknowledge from the controller ends the read.
                        state_reg <= ST_IGNORE;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (is_read_reg)
                        begin
                            // Release the ack and present the first bit, MSB first.
                            sda_oe_reg <= !tx_reg[7];
                            state_reg <= ST_RD_DATA;
                        end
                        else
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_WR_DATA;
                        end
                    end
                end
                ST_WR_ACK:
                begin
                    // The acknowledge ends on the clock's fall; the next byte follows.
                    if (scl_fall)
                    begin
                        sda_oe_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_WR_DATA;
                    end
                end
                ST_RD_DATA:
                begin
                    // Data changes only while the clock is low.
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == 4'h7)
                        begin
                            // Hand the line to the controller for its acknowledge.
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_RD_ACK;
                        end
                        else
                        begin
                            sda_oe_reg <= !tx_reg[3'h6 - bit_cnt_reg[2:0]];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                default:
                begin
                    // Idle and ignoring states never drive the data line.
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Flag and alert next values: clearing at a sample wins over setting by a live change.
    always_comb
    begin
        if (snap_io)
        begin
            // New snapshot equals the sampled inputs, so nothing is pending afterwards.
            flags_next = 8'h00;
        end
        else
        begin
            flags_next = flags_reg | (snapshot_reg ^ io_s);
        end
        if (stop_det)
        begin
            hold_next = 1'b0;
        end
        else if (snap_io && is_read_reg)
        begin
            hold_next = 1'b1;
        end
        else
        begin
            hold_next = hold_reg;
        end
    end

    // Snapshot, latched flags and the open-drain alert driver.
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            snapshot_reg <= 8'h00;
            flags_reg <= 8'h00;
            saved_flags_reg <= 8'h00;
            hold_reg <= 1'b0;
            alert_oe_reg <= 1'b0;
        end
        else
        begin
            if (snap_io)
            begin
                // Sent data becomes the new reference; old flags are kept for the next byte.
                snapshot_reg <= io_s;
                saved_flags_reg <= flags_reg;
            end
            flags_reg <= flags_next;
            hold_reg <= hold_next;
            alert_oe_reg <= (|flags_next) && !hold_next;
        end
    end

    // Port drivers follow each acknowledged written byte as a whole.
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            io_oe_reg <= IO_OE_RESET;
            pp_out_reg <= PP_RESET;
        end
        else if (wr_apply)
        begin
            if (is_pp_reg)
            begin
                pp_out_reg <= shift_reg;
            end
            else
            begin
                // A zero bit pulls the open-drain port low.
                io_oe_reg <= ~shift_reg;
            end
        end
    end

    // Open-drain pins only ever drive low; the serial clock is never driven.
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign open_drain_io_ports_out = 8'h00;
    assign open_drain_io_ports_oe = io_oe_reg;
    assign push_pull_outputs = pp_out_reg;
    assign change_alert_n_out = 1'b0;
    assign change_alert_oe = alert_oe_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    property p_start_opens;
        start_det |=> (state_reg == ST_ADDR) && !sda_oe_reg;
    endproperty
    a_start_opens: assert property (p_start_opens) else $error("START did not open address phase");

    property p_stop_frees;
        stop_det && !start_det |=> (state_reg == ST_IDLE) && !sda_oe_reg;
    endproperty
    a_stop_frees: assert property (p_stop_frees) else $error("STOP did not free the bus");

    property p_ignore_silent;
        (state_reg == ST_IGNORE) |-> !sda_oe_reg;
    endproperty
    a_ignore_silent: assert property (p_ignore_silent) else $error("Data driven for foreign address");

    property p_ack_drives;
        (state_reg == ST_ADDR_ACK) || (state_reg == ST_WR_ACK) |-> sda_oe_reg;
    endproperty
    a_ack_drives: assert property (p_ack_drives) else $error("Acknowledge not driven low");

    property p_hold_quiet;
        hold_reg |-> !change_alert_oe;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet) else $error("Alert raised during read");

    property p_alert_follows;
        ((|flags_reg) && !hold_reg) |-> change_alert_oe;
    endproperty
    a_alert_follows: assert property (p_alert_follows) else $error("Pending change without alert");

    property p_snap_clears;
        snap_io |=> (flags_reg == 8'h00) && (saved_flags_reg == $past(flags_reg)) && !change_alert_oe;
    endproperty
    a_snap_clears: assert property (p_snap_clears) else $error("Flags not saved and cleared");

    property p_write_applies;
        wr_apply && is_pp_reg |=> push_pull_outputs == $past(shift_reg);
    endproperty
    a_write_applies: assert property (p_write_applies) else $error("Written byte not on outputs");

    property p_read_stable;
        (state_reg == ST_RD_DATA) && scl_s && scl_prev_reg |-> $stable(sda_oe_reg);
    endproperty
    a_read_stable: assert property (p_read_stable) else $error("Data changed while clock high");

    property p_prefix;
        strap_done_reg |-> (io_addr_reg[6:4] == IO_PREFIX) && (pp_addr_reg[3:0] == io_addr_reg[3:0]);
    endproperty
    a_prefix: assert property (p_prefix) else $error("Address prefix or straps wrong");

endmodule : pxa_expander

`default_nettype wire

// File: rtl/pxa_pkg.sv
/*
 * Shared constants, state type and strap decoding for the two-wire port expander target.
 * Assumes a single 50 MHz system clock; the serial clock is sampled as plain data.
 */
package pxa_pkg;

    // Width of one serial byte and of each port group.
    localparam int BYTE_W = 8;
    // Width of a target address without the direction bit.
    localparam int ADDR_W = 7;
    // Bits of a byte counted before the acknowledge slot.
    localparam logic [3:0] BIT_LAST = 4'h8;
    // Fixed top three address bits of the open-drain group.
    localparam logic [2:0] IO_PREFIX = 3'h6;
    // Fixed top three address bits of the push-pull group.
    localparam logic [2:0] PP_PREFIX = 3'h5;
    // Strap connection codes as presented on the strap inputs.
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_SUPPLY = 2'h1;
    localparam logic [1:0] STRAP_CLK = 2'h2;
    localparam logic [1:0] STRAP_DATA = 2'h3;
    // Cycles after reset release before the synchronised straps are caught.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // Reset state of the open-drain pull-down enables (all released).
    localparam logic [7:0] IO_OE_RESET = 8'h00;
    // Reset state of the push-pull outputs.
    localparam logic [7:0] PP_RESET = 8'hff;
    // Reset value of the pin synchroniser: clock and data idle high.
    localparam logic [21:0] SYNC_RESET = 22'h300000;

    // Serial protocol states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } pxa_state_type;

    // Address bits 3..2 selected by the high strap.
    function automatic logic [1:0] strap_high_bits(input logic [1:0] code);
        logic [1:0] bits;
        bits = 2'h0;
        case (code)
            STRAP_CLK: bits = 2'h0;
            STRAP_DATA: bits = 2'h1;
            STRAP_GND: bits = 2'h2;
            default: bits = 2'h3;
        endcase
        return bits;
    endfunction : strap_high_bits

    // Address bits 1..0 selected by the low strap.
    function automatic logic [1:0] strap_low_bits(input logic [1:0] code);
        logic [1:0] bits;
        bits = 2'h0;
        case (code)
            STRAP_GND: bits = 2'h0;
            STRAP_SUPPLY: bits = 2'h1;
            STRAP_CLK: bits = 2'h2;
            default: bits = 2'h3;
        endcase
        return bits;
    endfunction : strap_low_bits

endpackage : pxa_pkg

// File: rtl/pxa_bit_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes the bundle holds independent levels; no word coherence is promised.
 */
`timescale 1ns/1ps
`default_nettype none

module pxa_bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta_reg;

    // Both stages load the reset constant and then follow the pins.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= RESET_VALUE;
            dout <= RESET_VALUE;
        end
        else
        begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end

endmodule : pxa_bit_sync

`default_nettype wire

// File: test/pxa_bus_ctrl.sv
/*
 * Behavioural two-wire bus controller that faces the expander in the bench.
 * Assumes the bench resolves the data line with a pullup and calls these tasks after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pxa_bus_ctrl (
    input wire logic ref_clk,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    // Both lines are released while the bus is idle, and the clock stands still.
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Waits a number of system clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // The data line falls while the clock is high, then the clock falls.
    task automatic start();
        tick(1);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask : start

    // One bit per clock pulse; data only changes while the clock is low.
    task automatic bit_cycle(input logic b, output logic r);
        tick(2);
        sda_low <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        r = sda_line;
        scl <= 1'b0;
    endtask : bit_cycle

    // Eight bits MSB first, then the ninth acknowledge clock.
    task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], r[i]);
        bit_cycle(a, ack);
    endtask : xfer

    // The data line rises while the clock is high, leaving the bus idle.
    task automatic stop();
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask : stop
endmodule : pxa_bus_ctrl

`default_nettype wire

// File: test/test_pxa_expander.sv
/*
 * Self-checking bench of the expander: writes, reads, a foreign address and the change alert.
 * Assumes the controller model in pxa_bus_ctrl.sv; straps give the low address bits 0110.
 */
`timescale 1ns/1ps
`default_nettype none

module test_pxa_expander;
    import pxa_pkg::*;
    logic ref_clk, rst_n, scl, sda_low, sda_oe, alert_oe, ack, sda_out, alert_n;
    logic [7:0] io_ext, io_oe, pp_out, pp_force, rd, io_out;
    logic [1:0] strap_hi, strap_lo;
    int errors, n_tests;
    // Expected addresses: fixed prefix, then strap bits 01 and 10.
    localparam logic [6:0] IO_ADDR = 7'h66;
    localparam logic [6:0] PP_ADDR = 7'h56;
    // Data line with its pullup; port pins pulled low where enabled.
    wire logic sda_line = ~((sda_oe & ~sda_out) | sda_low);
    wire logic [7:0] io_pins = io_ext & ~(io_oe & ~io_out);
    // Push-pull pins follow the drive unless the bench forces them.
    wire logic [7:0] pp_in = pp_out ^ pp_force;

    pxa_bus_ctrl u_pxa_bus_ctrl (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    pxa_expander u_pxa_expander (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_high(strap_hi), .addr_strap_low(strap_lo), .open_drain_io_ports_in(io_pins),
        .open_drain_io_ports_out(io_out), .open_drain_io_ports_oe(io_oe), .push_pull_outputs_in(pp_in),
        .push_pull_outputs(pp_out), .change_alert_n_out(alert_n), .change_alert_oe(alert_oe)
    );

    // The system clock toggles every half period of 10 ns.
    always #10 ref_clk = ~ref_clk;

    // Compares one value and counts it.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // START then the address byte; the acknowledge lands in ack.
    task automatic addr(input logic [6:0] a, input logic rw);
        u_pxa_bus_ctrl.start();
        u_pxa_bus_ctrl.xfer({a, rw}, 1'b1, rd, ack);
    endtask : addr

    // Write to the push-pull group, then a foreign address that must be ignored.
    task automatic t_write_pp();
        addr(PP_ADDR, 1'b0);
        check({7'h0, ack}, 8'h00);
        u_pxa_bus_ctrl.xfer(8'h3c, 1'b1, rd, ack);
        check({7'h0, ack}, 8'h00);
        u_pxa_bus_ctrl.stop();
        check(pp_out, 8'h3c);
        addr(7'h67, 1'b0);
        check({7'h0, ack}, 8'h01);
        u_pxa_bus_ctrl.xfer(8'h00, 1'b1, rd, ack);
        u_pxa_bus_ctrl.stop();
        check(pp_out, 8'h3c);
        $display("t_write_pp done");
    endtask : t_write_pp

    // Two-byte write to the open-drain group; pin changes it causes raise the alert.
    task automatic t_write_io();
        addr(IO_ADDR, 1'b0);
        check({7'h0, ack}, 8'h00);
        u_pxa_bus_ctrl.xfer(8'h5a, 1'b1, rd, ack);
        check(io_oe, 8'ha5);
        u_pxa_bus_ctrl.xfer(8'hff, 1'b1, rd, ack);
        u_pxa_bus_ctrl.stop();
        check(io_oe, 8'h00);
        check(io_out | {6'h0, sda_out, alert_n}, 8'h00);
        check({7'h0, alert_oe}, 8'h01);
        io_ext <= 8'hf2;
        $display("t_write_io done");
    endtask : t_write_io

    // Two-byte read of push-pull pins, forced then released, shows the real level each time.
    task automatic t_read_pp();
        pp_force <= 8'h81;
        addr(PP_ADDR, 1'b1);
        pp_force <= 8'h00;
        u_pxa_bus_ctrl.xfer(8'hff, 1'b0, rd, ack);
        check(rd, 8'hbd);
        u_pxa_bus_ctrl.xfer(8'hff, 1'b1, rd, ack);
        u_pxa_bus_ctrl.stop();
        check(rd, 8'h3c);
        check({7'h0, alert_oe}, 8'h01);
        $display("t_read_pp done");
    endtask : t_read_pp

    // Two-byte read of the open-drain group with a change during the read.
    task automatic t_read_io();
        addr(IO_ADDR, 1'b1);
        check({7'h0, alert_oe}, 8'h00);
        u_pxa_bus_ctrl.xfer(8'hff, 1'b0, rd, ack);
        check(rd, 8'hf2);
        io_ext <= 8'hf3;
        u_pxa_bus_ctrl.xfer(8'hff, 1'b1, rd, ack);
        check(rd, 8'ha2);
        check({7'h0, alert_oe}, 8'h00);
        u_pxa_bus_ctrl.stop();
        check({7'h0, alert_oe}, 8'h01);
        $display("t_read_io done");
    endtask : t_read_io

    // Four-byte read: port data and flags alternate, each pair freshly sampled.
    task automatic t_read_multi();
        addr(IO_ADDR, 1'b1);
        u_pxa_bus_ctrl.xfer(8'hff, 1'b0, rd, ack);
        check(rd, 8'hf3);
        io_ext <= 8'hf7;
        u_pxa_bus_ctrl.xfer(8'hff, 1'b0, rd, ack);
        check(rd, 8'h01);
        u_pxa_bus_ctrl.xfer(8'hff, 1'b0, rd, ack);
        check(rd, 8'hf7);
        u_pxa_bus_ctrl.xfer(8'hff, 1'b1, rd, ack);
        check(rd, 8'h04);
        u_pxa_bus_ctrl.stop();
        check({7'h0, alert_oe}, 8'h00);
        $display("t_read_multi done");
    endtask : t_read_multi

    // Mid-run reset with new straps: only the newly strapped addresses answer.
    task automatic t_straps(input logic [1:0] hi, input logic [1:0] lo, input logic [3:0] low_bits);
        strap_hi <= hi;
        strap_lo <= lo;
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        addr(IO_ADDR, 1'b0);
        check({7'h0, ack}, 8'h01);
        u_pxa_bus_ctrl.stop();
        addr({IO_PREFIX, low_bits}, 1'b0);
        check({7'h0, ack}, 8'h00);
        u_pxa_bus_ctrl.stop();
        addr({PP_PREFIX, low_bits}, 1'b0);
        check({7'h0, ack}, 8'h00);
        u_pxa_bus_ctrl.stop();
        $display("t_straps done");
    endtask : t_straps

    // Cuts a hung run short.
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end

    // Reset, then the scenarios in order.
    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        io_ext = 8'hf0;
        pp_force = 8'h00;
        strap_hi = STRAP_DATA;
        strap_lo = STRAP_CLK;
        errors = 0;
        n_tests = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        t_write_pp();
        t_write_io();
        t_read_pp();
        t_read_io();
        t_read_multi();
        t_straps(STRAP_GND, STRAP_SUPPLY, 4'h9);
        t_straps(STRAP_SUPPLY, STRAP_GND, 4'hc);
        t_straps(STRAP_CLK, STRAP_DATA, 4'h3);
        give_verdict();
    end
endmodule : test_pxa_expander

`default_nettype wire
